// >>> include/cmpd_pkg.sv
package cmpd_pkg;

    // ==========================================================
    // Three-level pin encoding (board gives two comparator bits)
    // ==========================================================
    typedef enum logic [1:0] {
        CMPD_LVL_LOW,
        CMPD_LVL_MID,
        CMPD_LVL_HIGH
    } cmpd_level_t;

    // ==========================================================
    // Decoded modes
    // ==========================================================
    typedef enum logic [1:0] {
        CMPD_CTRL_HW,
        CMPD_CTRL_SERIAL,
        CMPD_CTRL_PARALLEL
    } cmpd_ctrl_t;

    typedef enum logic [1:0] {
        CMPD_JA_TX,
        CMPD_JA_OFF,
        CMPD_JA_RX
    } cmpd_ja_t;

    typedef struct packed {
        logic mux_bus;
        logic sep_strobes;
    } cmpd_bus_t;

    typedef struct packed {
        logic serial_en;
        logic parallel_en;
        logic hw_en;
    } cmpd_pins_t;

    // Level input bit positions: {is_high, is_mid}
    localparam int CMPD_LVL_HI_BIT = 1;
    localparam int CMPD_LVL_MID_BIT = 0;
    localparam int CMPD_SYNC_STAGES = 2;
    localparam int CMPD_MIN_SYNC_STAGES = 2;
    // Strap pins plus chip select, carried as one synchroniser word
    localparam int CMPD_PIN_COUNT = 8;
    // Comparators read high at reset, so chip select idles high and nothing starts
    localparam logic [CMPD_PIN_COUNT-1:0] CMPD_SYNC_RESET = 8'hFF;
    // Parallel bus codes as {bus mux select, bus style select}
    localparam logic [1:0] CMPD_PAR_NONMUX_RW = 2'h0;
    localparam logic [1:0] CMPD_PAR_NONMUX_SEP = 2'h1;
    localparam logic [1:0] CMPD_PAR_MUX_RW = 2'h2;
    localparam logic [1:0] CMPD_PAR_MUX_SEP = 2'h3;

endpackage

// >>> design/cmpd_control_mode_pin_decode.sv
`timescale 1ns/1ps
module cmpd_control_mode_pin_decode #(
    parameter int SYNC_STAGES = cmpd_pkg::CMPD_SYNC_STAGES
) (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic [1:0] CONTROL_METHOD_SELECT,
    input wire logic BUS_MUX_SELECT,
    input wire logic BUS_STYLE_SELECT,
    input wire logic LINE_CODE_SELECT,
    input wire logic [1:0] JITTER_ATTEN_POSITION,
    input wire logic CHIP_SELECT_N,
    output cmpd_pkg::cmpd_ctrl_t CONTROL_MODE,
    output cmpd_pkg::cmpd_bus_t BUS_STYLE,
    output cmpd_pkg::cmpd_pins_t PIN_GROUP_EN,
    output logic ZERO_SUPPRESS_EN,
    output cmpd_pkg::cmpd_ja_t JA_POSITION,
    output logic HOST_ACCESS_START,
    output logic HOST_SELECTED
);
    import cmpd_pkg::*;

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    // One flop alone would let a metastable strap reach the decode
    if (SYNC_STAGES < CMPD_MIN_SYNC_STAGES) begin : g_bad_sync
        $error("SYNC_STAGES below the two-flop minimum");
    end

    // ==========================================================
    // Pin synchronisers; straps may change at any time
    // ==========================================================
    logic [CMPD_PIN_COUNT-1:0] pins_raw;
    wire logic [CMPD_PIN_COUNT-1:0] pins_sync;
    assign pins_raw = {CONTROL_METHOD_SELECT, BUS_MUX_SELECT, BUS_STYLE_SELECT,
                       LINE_CODE_SELECT, JITTER_ATTEN_POSITION, CHIP_SELECT_N};

    // Only the last stage is read; earlier stages may still be settling
    for (genvar b = 0; b < CMPD_PIN_COUNT; b++) begin : g_sync
        logic [SYNC_STAGES-1:0] chain_reg;
        always_ff @(posedge SYS_CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                chain_reg <= {SYNC_STAGES{CMPD_SYNC_RESET[b]}};
            end else begin
                chain_reg <= {chain_reg[SYNC_STAGES-2:0], pins_raw[b]};
            end
        end
        assign pins_sync[b] = chain_reg[SYNC_STAGES-1];
    end

    // ==========================================================
    // Synchronised strap fields
    // ==========================================================
    logic [1:0] m2_s;
    logic m1_s;
    logic m0_s;
    logic code_s;
    logic [1:0] jas_s;
    logic cs_n_s;
    assign {m2_s, m1_s, m0_s, code_s, jas_s, cs_n_s} = pins_sync;

    // Comparator pair to level; high wins if both report
    function automatic cmpd_level_t to_level(input logic [1:0] v);
        cmpd_level_t l;
        l = CMPD_LVL_LOW;
        if (v[CMPD_LVL_HI_BIT]) begin
            l = CMPD_LVL_HIGH;
        end else if (v[CMPD_LVL_MID_BIT]) begin
            l = CMPD_LVL_MID;
        end
        return l;
    endfunction

    // ==========================================================
    // Level decode
    // ==========================================================
    cmpd_level_t ctrl_lvl;
    cmpd_level_t ja_lvl;
    cmpd_ctrl_t ctrl_next;
    cmpd_ja_t ja_next;
    assign ctrl_lvl = to_level(m2_s);
    assign ja_lvl = to_level(jas_s);

    always_comb begin
        case (ctrl_lvl)
            CMPD_LVL_HIGH: ctrl_next = CMPD_CTRL_PARALLEL;
            CMPD_LVL_MID: ctrl_next = CMPD_CTRL_SERIAL;
            default: ctrl_next = CMPD_CTRL_HW;
        endcase
    end

    always_comb begin
        case (ja_lvl)
            CMPD_LVL_HIGH: ja_next = CMPD_JA_RX;
            CMPD_LVL_MID: ja_next = CMPD_JA_OFF;
            default: ja_next = CMPD_JA_TX;
        endcase
    end

    // Bus style only meaningful in parallel mode; held at zero otherwise
    cmpd_bus_t bus_next;
    always_comb begin
        bus_next = '0;
        if (ctrl_next == CMPD_CTRL_PARALLEL) begin
            case ({m1_s, m0_s})
                CMPD_PAR_NONMUX_RW: begin
                    bus_next.mux_bus = 1'b0;
                    bus_next.sep_strobes = 1'b0;
                end
                CMPD_PAR_NONMUX_SEP: begin
                    bus_next.mux_bus = 1'b0;
                    bus_next.sep_strobes = 1'b1;
                end
                CMPD_PAR_MUX_RW: begin
                    bus_next.mux_bus = 1'b1;
                    bus_next.sep_strobes = 1'b0;
                end
                default: begin
                    bus_next.mux_bus = 1'b1;
                    bus_next.sep_strobes = 1'b1;
                end
            endcase
        end
    end

    // Hardware-mode straps; in host modes software owns these settings
    logic zs_next;
    cmpd_ja_t ja_pos_next;
    always_comb begin
        zs_next = 1'b0;
        ja_pos_next = CMPD_JA_OFF;
        if (ctrl_next == CMPD_CTRL_HW) begin
            zs_next = code_s;
            ja_pos_next = ja_next;
        end
    end

    // ==========================================================
    // Output registers
    // ==========================================================
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CONTROL_MODE <= CMPD_CTRL_HW;
        end else begin
            CONTROL_MODE <= ctrl_next;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PIN_GROUP_EN <= '0;
        end else begin
            PIN_GROUP_EN.hw_en <= (ctrl_next == CMPD_CTRL_HW);
            PIN_GROUP_EN.serial_en <= (ctrl_next == CMPD_CTRL_SERIAL);
            PIN_GROUP_EN.parallel_en <= (ctrl_next == CMPD_CTRL_PARALLEL);
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            BUS_STYLE <= '0;
        end else begin
            BUS_STYLE <= bus_next;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ZERO_SUPPRESS_EN <= 1'b0;
        end else begin
            ZERO_SUPPRESS_EN <= zs_next;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            JA_POSITION <= CMPD_JA_OFF;
        end else begin
            JA_POSITION <= ja_pos_next;
        end
    end

    // ==========================================================
    // Chip select handshake
    // ==========================================================
    logic cs_n_prev_reg;
    logic host_mode;
    logic cs_fall;
    assign host_mode = (ctrl_next != CMPD_CTRL_HW);
    // Each access needs a new falling edge; a held-low select starts nothing
    assign cs_fall = cs_n_prev_reg && !cs_n_s;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cs_n_prev_reg <= 1'b1;
        end else begin
            cs_n_prev_reg <= cs_n_s;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            HOST_ACCESS_START <= 1'b0;
        end else begin
            HOST_ACCESS_START <= cs_fall && host_mode;
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            HOST_SELECTED <= 1'b0;
        end else begin
            HOST_SELECTED <= !cs_n_s && host_mode;
        end
    end

endmodule

// >>> dv/cmpd_chk.sv
`timescale 1ns/1ps
// ==========================================================
// Strap decode checks, armed once the sync pipe holds post-reset pins
module cmpd_chk import cmpd_pkg::*; (
    input wire logic SYS_CLK, ARST_N, BUS_MUX_SELECT, BUS_STYLE_SELECT, LINE_CODE_SELECT, CHIP_SELECT_N,
    input wire logic [1:0] CONTROL_METHOD_SELECT, JITTER_ATTEN_POSITION,
    input cmpd_ctrl_t CONTROL_MODE, input cmpd_bus_t BUS_STYLE, input cmpd_pins_t PIN_GROUP_EN,
    input cmpd_ja_t JA_POSITION, input wire logic ZERO_SUPPRESS_EN, HOST_ACCESS_START, HOST_SELECTED);
    logic [1:0] up_reg;
    wire logic armed = up_reg == 2'h3;
    wire logic hw = CONTROL_MODE == CMPD_CTRL_HW;
    function automatic logic [1:0] lvl(logic [1:0] v);
        return v[1] ? 2'h2 : {1'b0, v[0]};
    endfunction
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    // Pipe is three deep, so $past before the fourth edge would see reset-time pins
    always_ff @(posedge SYS_CLK or negedge ARST_N) up_reg <= !ARST_N ? 2'h0 : up_reg + {1'b0, !armed};
    chk_mode_decode: assert property (armed |-> CONTROL_MODE == lvl($past(CONTROL_METHOD_SELECT, 3)))
        else $error("control mode wrong");
    chk_bus_style: assert property (armed |-> BUS_STYLE == (CONTROL_MODE == CMPD_CTRL_PARALLEL ?
        {$past(BUS_MUX_SELECT, 3), $past(BUS_STYLE_SELECT, 3)} : 2'h0)) else $error("bus style wrong");
    chk_pin_group: assert property (armed |-> PIN_GROUP_EN == {CONTROL_MODE == CMPD_CTRL_SERIAL,
        CONTROL_MODE == CMPD_CTRL_PARALLEL, hw}) else $error("pin group wrong");
    chk_line_code: assert property (armed |-> ZERO_SUPPRESS_EN == (hw && $past(LINE_CODE_SELECT, 3)))
        else $error("line code wrong");
    chk_jitter_pos: assert property (armed |-> JA_POSITION == (hw ? lvl($past(JITTER_ATTEN_POSITION, 3)) : 2'h1))
        else $error("jitter position wrong");
    chk_select_level: assert property (armed |-> HOST_SELECTED == (!hw && !$past(CHIP_SELECT_N, 3)))
        else $error("select level wrong");
    chk_start_cause: assert property (armed |-> HOST_ACCESS_START ==
        (!hw && $past(CHIP_SELECT_N, 4) && !$past(CHIP_SELECT_N, 3))) else $error("start pulse wrong");
    chk_start_once: assert property (HOST_ACCESS_START |=> !HOST_ACCESS_START)
        else $error("start pulse too long");
    cover property (CONTROL_MODE == CMPD_CTRL_PARALLEL && BUS_STYLE == 2'h3);
    cover property (HOST_ACCESS_START);
    cover property (JA_POSITION == CMPD_JA_RX);
endmodule
bind cmpd_control_mode_pin_decode cmpd_chk u_chk (.*);

// >>> dv/cmpd_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host side: one fresh chip-select fall per access, held low for the whole access
module cmpd_host_model (
    input wire logic clk,
    input wire logic access_req,
    output logic cs_n
);
    logic [2:0] left_reg = 3'h0;
    assign cs_n = left_reg == 3'h0;
    always @(negedge clk) left_reg <= left_reg != 3'h0 ? left_reg - 3'h1 : (access_req ? 3'h6 : 3'h0);
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ps
// ==========================================================
// Strap decode bench
module testbench;
    import cmpd_pkg::*;
    logic SYS_CLK = 1'b0, ARST_N = 1'b0, mux = 1'b0, sty = 1'b0, lcs = 1'b0, req = 1'b0, cs_n, zs, start, sel;
    logic [1:0] cms = 2'h0, jap = 2'h0;
    logic [31:0] seed = 32'hDF97;
    int fail_count = 0, checked = 0;
    cmpd_ctrl_t ctrl;
    cmpd_bus_t bus;
    cmpd_pins_t grp;
    cmpd_ja_t ja;
    cmpd_control_mode_pin_decode uut (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .CONTROL_METHOD_SELECT(cms),
        .BUS_MUX_SELECT(mux), .BUS_STYLE_SELECT(sty), .LINE_CODE_SELECT(lcs), .JITTER_ATTEN_POSITION(jap),
        .CHIP_SELECT_N(cs_n), .CONTROL_MODE(ctrl), .BUS_STYLE(bus), .PIN_GROUP_EN(grp), .ZERO_SUPPRESS_EN(zs),
        .JA_POSITION(ja), .HOST_ACCESS_START(start), .HOST_SELECTED(sel));
    cmpd_host_model host (.clk(SYS_CLK), .access_req(req), .cs_n(cs_n));
    initial forever #2.5 SYS_CLK = ~SYS_CLK;
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // Packs {mode, bus, pin groups, zero suppress, jitter} as the outputs are ordered
    function automatic logic [9:0] want(logic [1:0] c, j, logic m, s, l);
        logic [1:0] md;
        md = c[1] ? 2'h2 : {1'b0, c[0]};
        return {md, md == 2'h2 ? {m, s} : 2'h0, md == 2'h1, md == 2'h2, md == 2'h0, md == 2'h0 && l,
            md == 2'h0 ? (j[1] ? 2'h2 : {1'b0, j[0]}) : 2'h1};
    endfunction
    task automatic check(string name, logic [9:0] seen, logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Straps settle, then one host access; hardware mode must ignore it
    task automatic apply(logic [1:0] c, j, logic m, s, l);
        {cms, jap, mux, sty, lcs} = {c, j, m, s, l};
        repeat (4) @(negedge SYS_CLK);
        check("straps", {ctrl, bus, grp, zs, ja}, want(c, j, m, s, l));
        req <= 1'b1;
        @(negedge SYS_CLK);
        req <= 1'b0;
        repeat (3) @(negedge SYS_CLK);
        check("access", {start, sel}, {2{c != 2'h0}});
        @(negedge SYS_CLK);
        check("hold", {start, sel}, {1'b0, c != 2'h0});
        repeat (6) @(negedge SYS_CLK);
    endtask
    initial begin
        repeat (10) @(negedge SYS_CLK);
        ARST_N = 1'b1;
        for (int i = 0; i < 16; i++) apply(i[1:0], i[3:2], i[0], i[1], i[2]);
        for (int i = 0; i < 8; i++) apply({1'b1, i[2]}, 2'h3, i[1], i[0], 1'b1);
        repeat (60) begin
            seed = xs(seed);
            apply(seed[1:0], seed[3:2], seed[4], seed[5], seed[6]);
        end
        end_of_test();
    end
    initial begin
        #50000;
        fail_count++;
        end_of_test();
    end
endmodule
